/* File: logic/ckd_output_ctrl.sv */
// Output configuration decode and pin control of a six-bank clock driver.
// Assumes pins arrive asynchronously and pass two flip-flops; Wishbone master on clk_i.
//
// Summary of operation
// RQ1 - Power-down high runs outputs; low tri-states or parks per disable-style bit.
// RQ2 - Stop-level 0 parks true outputs high, complements low; 1 reverses.
// RQ3 - Two-bit interface select per bank: 2.5V, 1.8V, HSTL; 11 reserved.
// RQ4 - Skew code: zero, inverted, divide by two, divide by four.
// RQ5 - Undefined skew codes act as zero skew, no inversion, no division.
// RQ6 - Feedback divide code maps to N of 1-6, 8, 10, 12; others reserved.
// RQ7 - Software limits feedback post-divide according to N.
// RQ8 - All banks disabled by pins resets all output divider state.
// RQ9 - Bank enabled when pin and bit both low; dividers restart cleanly.
// RQ10 - Divided feedback output stops while the divider reset holds.
// RQ11 - Enable bits 56..52 combine with pins and style bit per bank.
// RQ12 - Enable changes apply only at an output clock boundary.
`timescale 1ns/1ps
module ckd_output_ctrl (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire logic power_down_n_i,
	input wire logic disable_style_select_i,
	input wire logic [4:0] bank_output_enable_n_i,
	output ckd_pkg::ckd_pin_s [5:0] bank_clock_out_o,
	output logic [1:0] bank_if_sel_o [6],
	output logic [3:0] feedback_mult_o,
	output logic feedback_mult_valid_o
);
	import ckd_pkg::*;
	// Register window, decoded on the low four address bits only. Offset 0x0 holds
	// configuration bits 31..0 and offset 0x4 bits 59..32 in its low 28 bits. Offset 0x8 is a
	// read-only status word: multiply valid at 10, divider reset at 9, enables at 8..4 and the
	// decoded multiply at 3..0. Unmapped offsets read zero and drop writes, yet still answer,
	// so a stray access never stalls the bus.
	localparam logic [3:0] ADR_CFG_LO = 4'h0;
	localparam logic [3:0] ADR_CFG_HI = 4'h4;
	localparam logic [3:0] ADR_STATUS = 4'h8;

	typedef struct packed {
		logic [59:0] cfg;
		logic ack;
		logic [31:0] rdat;
		logic [1:0] pd_s;
		logic [1:0] sty_s;
		logic [9:0] soe_s;
		logic [5:0] en;
		logic div_rst;
		ckd_pin_s [5:0] pins;
		logic [3:0] nmul;
		logic nval;
	} ckd_st_s;
	ckd_st_s st_q, st_d;
	ckd_bank_cfg_s [5:0] bcfg;
	logic [5:0] phase, bedge;

	// Decode of a five-bit skew field; undefined codes fall to zero skew.
	function automatic ckd_bank_cfg_s dec_skew(input logic [4:0] c, input logic [1:0] ifs);
		ckd_bank_cfg_s r;
		r.ifsel = ckd_if_e'(ifs); // [RQ3]
		r.invert = (c == SKEW_INV); // [RQ4]
		case (c)
			SKEW_DIV2: r.div = CKD_DIV_2; // [RQ4]
			SKEW_DIV4: r.div = CKD_DIV_4;
			default: r.div = CKD_DIV_1; // [RQ5]
		endcase
		return r;
	endfunction : dec_skew

	// Feedback ratio decode; reserved codes flag invalid.
	function automatic logic [4:0] dec_n(input logic [3:0] c);
		case (c)
			4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: dec_n = {1'b1, c + 4'h1}; // [RQ6]
			4'h6: dec_n = {1'b1, 4'h8};
			4'h7: dec_n = {1'b1, 4'ha};
			4'h8: dec_n = {1'b1, 4'hc};
			default: dec_n = {1'b0, 4'h1};
		endcase
	endfunction : dec_n

	// Drive state of one bank. Power-down overrides every other cause; otherwise a bank runs
	// only while enabled, and the divided feedback pair is held while the dividers sit in reset.
	function automatic ckd_mode_e bank_mode(input logic pd_n, input logic gate, input logic en,
		input logic fb_hold);
		ckd_mode_e md;
		if (!pd_n) begin
			md = gate ? CKD_ST_PARK : CKD_ST_TRI; // [RQ1]
		end else if (en && !fb_hold) begin
			md = CKD_ST_RUN; // [RQ10]
		end else begin
			md = gate ? CKD_ST_PARK : CKD_ST_TRI; // [RQ11]
		end
		return md;
	endfunction : bank_mode

	// Pin triple for one drive state. A released pair shows low on both lines, so a load that
	// ignores the enable never sees an edge from a bank that is switched off.
	function automatic ckd_pin_s drive_pin(input ckd_mode_e md, input logic lvl,
		input logic stop_lvl);
		ckd_pin_s p;
		case (md)
			CKD_ST_RUN: p = '{true_o: lvl, comp_o: ~lvl, oe_n: 1'b0};
			CKD_ST_PARK: p = '{true_o: ~stop_lvl, comp_o: stop_lvl, oe_n: 1'b0}; // [RQ2]
			CKD_ST_TRI: p = '{true_o: 1'b0, comp_o: 1'b0, oe_n: 1'b1};
			default: p = '{true_o: 1'b0, comp_o: 1'b0, oe_n: 1'b1};
		endcase
		return p;
	endfunction : drive_pin

	// Status word as software sees it; the bits above the multiply valid flag read zero.
	function automatic logic [31:0] status_word(input ckd_st_s s);
		return {21'h0, s.nval, s.div_rst, s.en[4:0], s.nmul};
	endfunction : status_word

	// Banks are numbered with feedback at the top; bank b skew starts at 25 - 5b.
	genvar g;
	generate
		for (g = 0; g < NBANK; g++) begin : g_bank
			assign bcfg[g] = dec_skew(st_q.cfg[25 - 5 * g +: DIV_W],
				st_q.cfg[IFSEL_LSB + 2 * (NBANK - 1 - g) +: 2]);
			ckd_bank_div u_div (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.div_rst_i(st_q.div_rst),
				.cfg_i(bcfg[g]),
				.phase_o(phase[g]),
				.edge_o(bedge[g])
			);
		end
	endgenerate

	// Bus slave, pin synchronisers, enable gating and pin drive.
	always_comb begin
		logic [5:0] req_en;
		logic park;
		logic gated;
		logic [3:0] a;
		ckd_mode_e m;
		logic fb_hold;
		req_en = '0;
		fb_hold = 1'b0;
		park = 1'b0;
		gated = 1'b0;
		a = wb_adr_i[3:0];
		m = CKD_ST_RUN;
		st_d = st_q;
		// Two-flop synchronisers for the pins; only the second stage feeds any decision.
		st_d.pd_s = {st_q.pd_s[0], power_down_n_i};
		st_d.sty_s = {st_q.sty_s[0], disable_style_select_i};
		st_d.soe_s = {st_q.soe_s[4:0], bank_output_enable_n_i};
		// One ack per request; zero wait beyond a single registered cycle.
		st_d.ack = wb_cyc_i && wb_stb_i && !st_q.ack;
		if (wb_cyc_i && wb_stb_i && !st_q.ack) begin
			if (wb_we_i && a == ADR_CFG_LO) begin
				for (int i = 0; i < 4; i++) begin
					if (wb_sel_i[i]) st_d.cfg[8 * i +: 8] = wb_dat_i[8 * i +: 8];
				end
			end else if (wb_we_i && a == ADR_CFG_HI) begin
				for (int i = 0; i < 4; i++) begin
					if (wb_sel_i[i] && i < 3) st_d.cfg[32 + 8 * i +: 8] = wb_dat_i[8 * i +: 8];
					if (wb_sel_i[i] && i == 3) st_d.cfg[56 +: 4] = wb_dat_i[24 +: 4];
				end
			end
			case (a)
				ADR_CFG_LO: st_d.rdat = st_q.cfg[31:0];
				ADR_CFG_HI: st_d.rdat = {4'h0, st_q.cfg[59:32]};
				ADR_STATUS: st_d.rdat = status_word(st_q);
				default: st_d.rdat = 32'h0;
			endcase
		end
		// The ratio decode is registered, so software and the outputs see one settled value.
		{st_d.nval, st_d.nmul} = dec_n(st_q.cfg[FBN_LSB +: 4]);
		// Pin and bit both low enable a bank; feedback follows any bank.
		req_en[4:0] = ~st_q.soe_s[9:5] & ~st_q.cfg[SOE_LSB +: 5]; // [RQ9] [RQ11]
		req_en[FB_IDX] = |req_en[4:0];
		st_d.div_rst = &st_q.soe_s[9:5]; // [RQ8]
		// Either the pin or the stored bit selects gating; neither forces a running bank off.
		gated = st_q.sty_s[1] | st_q.cfg[STYLE_BIT]; // [RQ1]
		park = st_q.cfg[STOP_LVL_BIT]; // [RQ2]
		for (int b = 0; b < NBANK; b++) begin
			// Changing only at a period boundary avoids runt pulses.
			if (bedge[b]) st_d.en[b] = req_en[b]; // [RQ12]
			// The divided feedback pair must not toggle while the dividers are held in reset.
			fb_hold = (b == FB_IDX) && st_q.div_rst && (bcfg[b].div != CKD_DIV_1); // [RQ10]
			m = bank_mode(st_q.pd_s[1], gated, st_q.en[b], fb_hold);
			st_d.pins[b] = drive_pin(m, phase[b] ^ bcfg[b].invert, park); // [RQ2]
		end
	end

	// Single register stage holds all state.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '0;
			st_q.cfg <= CFG_RST;
			for (int b = 0; b < NBANK; b++) begin
				st_q.pins[b] <= drive_pin(CKD_ST_TRI, 1'b0, 1'b0); // Released until pins sync.
			end
		end else begin
			st_q <= st_d;
		end
	end

	assign wb_ack_o = st_q.ack;
	assign wb_dat_o = st_q.rdat;
	assign bank_clock_out_o = st_q.pins;
	assign feedback_mult_o = st_q.nmul;
	assign feedback_mult_valid_o = st_q.nval;
	// The interface selects leave straight from the configuration register.
	generate
		for (g = 0; g < NBANK; g++) begin : g_if
			assign bank_if_sel_o[g] = st_q.cfg[IFSEL_LSB + 2 * (NBANK - 1 - g) +: 2]; // [RQ3]
		end
	endgenerate
endmodule : ckd_output_ctrl

/* File: logic/ckd_pkg.sv */
// Package for the clock driver output configuration block.
// Assumes one system clock domain; the configuration word is loaded by an outer agent.
package ckd_pkg;
	localparam int NBANK = 6; // Five output banks plus the feedback bank, index 5.
	localparam int FB_IDX = 5;
	localparam int CFG_W = 60;
	// Field positions inside the configuration word.
	localparam int DIV_W = 5;
	localparam int FBN_LSB = 48;
	localparam int SOE_LSB = 52;
	localparam int STOP_LVL_BIT = 58;
	localparam int STYLE_BIT = 59;
	localparam int IFSEL_LSB = 36;
	// Reset values.
	localparam logic [59:0] CFG_RST = 60'h0;
	localparam logic [3:0] CNT_RST = 4'h0;
	// Skew or frequency codes.
	localparam logic [4:0] SKEW_ZERO = 5'h00;
	localparam logic [4:0] SKEW_INV = 5'h10;
	localparam logic [4:0] SKEW_DIV2 = 5'h11;
	localparam logic [4:0] SKEW_DIV4 = 5'h12;
	// Interface selects.
	typedef enum logic [1:0] {
		CKD_IF_LV25 = 2'h0,
		CKD_IF_LV18 = 2'h1,
		CKD_IF_HSTL = 2'h2,
		CKD_IF_RSVD = 2'h3
	} ckd_if_e;
	// Bank drive states, one-hot.
	typedef enum logic [2:0] {
		CKD_ST_RUN = 3'h1,
		CKD_ST_TRI = 3'h2,
		CKD_ST_PARK = 3'h4
	} ckd_mode_e;
	typedef enum logic [1:0] {
		CKD_DIV_1 = 2'h0,
		CKD_DIV_2 = 2'h1,
		CKD_DIV_4 = 2'h2
	} ckd_div_e;
	// Decoded per bank setting.
	typedef struct packed {
		logic invert;
		ckd_div_e div;
		ckd_if_e ifsel;
	} ckd_bank_cfg_s;
	// Output pin triple of one bank.
	typedef struct packed {
		logic true_o;
		logic comp_o;
		logic oe_n;
	} ckd_pin_s;
endpackage : ckd_pkg

/* File: logic/ckd_bank_div.sv */
// One bank post-divider with a boundary-aligned enable.
// Assumes clk_i is the internal VCO-derived clock seen as a synchronous clock here.
`timescale 1ns/1ps
module ckd_bank_div (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic div_rst_i,
	input ckd_pkg::ckd_bank_cfg_s cfg_i,
	output logic phase_o,
	output logic edge_o
);
	import ckd_pkg::*;
	typedef struct packed {
		logic [3:0] cnt;
	} ckd_div_st_s;
	ckd_div_st_s st_q, st_d;
	logic [3:0] limit;

	// Count length per divide; the counter wraps at each output period.
	always_comb begin
		st_d = st_q;
		case (cfg_i.div)
			CKD_DIV_2: limit = 4'h1;
			CKD_DIV_4: limit = 4'h3;
			default: limit = 4'h0;
		endcase
		if (div_rst_i) begin
			st_d.cnt = CNT_RST; // [RQ8] [RQ10]
		end else if (st_q.cnt >= limit) begin
			st_d.cnt = CNT_RST; // [RQ9]
		end else begin
			st_d.cnt = st_q.cnt + 4'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '{cnt: CNT_RST};
		end else begin
			st_q <= st_d;
		end
	end

	// Phase is high for the first half of the divided period, and stays high when undivided.
	always_comb begin
		case (cfg_i.div)
			CKD_DIV_2: phase_o = (st_q.cnt == 4'h0);
			CKD_DIV_4: phase_o = (st_q.cnt < 4'h2);
			default: phase_o = 1'b1;
		endcase
		edge_o = (st_q.cnt == CNT_RST);
	end
endmodule : ckd_bank_div

/* File: dv/ckd_output_ctrl_props.sv */
// Port checker for the output control block.
// Assumes pins held steady settle within six clocks.
`timescale 1ns/1ps
module ckd_output_ctrl_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic power_down_n_i,
	input wire logic disable_style_select_i,
	input wire ckd_pkg::ckd_pin_s [5:0] bank_clock_out_o,
	input wire logic [3:0] feedback_mult_o,
	input wire logic feedback_mult_valid_o
);
	import ckd_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [5:0] oe_w;
	logic [5:0] tc_w;
	wire logic park_w = !power_down_n_i && disable_style_select_i;
	// Config bit 59 can only add gating, so the pin alone is a safe cause.
	always_comb begin
		for (int k = 0; k < 6; k++) begin
			oe_w[k] = bank_clock_out_o[k].oe_n;
			tc_w[k] = bank_clock_out_o[k].true_o ^ bank_clock_out_o[k].comp_o;
		end
	end
	property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack too long");
	property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
	property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_dat_hold; !wb_ack_o |-> $stable(wb_dat_o); endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
	property p_mult_ok; feedback_mult_valid_o |-> feedback_mult_o inside {[1:6], 8, 10, 12}; endproperty
	a_mult_ok: assert property (p_mult_ok) else $error("bad multiply");
	property p_park; park_w [*6] |-> oe_w == 6'h00; endproperty
	a_park: assert property (p_park) else $error("gated bank not driven");
	property p_park_hold; park_w [*7] |-> $stable(bank_clock_out_o); endproperty
	a_park_hold: assert property (p_park_hold) else $error("parked level moved");
	property p_pair; (~oe_w & ~tc_w) == 6'h00; endproperty
	a_pair: assert property (p_pair) else $error("pair not complementary");
	c_ack: cover property (wb_ack_o);
	c_valid: cover property (feedback_mult_valid_o);
	c_park: cover property (park_w [*7]);
endmodule : ckd_output_ctrl_props
bind ckd_output_ctrl ckd_output_ctrl_props ckd_output_ctrl_props_inst (.clk_i(clk_i),
	.rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.wb_dat_o(wb_dat_o), .power_down_n_i(power_down_n_i),
	.disable_style_select_i(disable_style_select_i), .bank_clock_out_o(bank_clock_out_o),
	.feedback_mult_o(feedback_mult_o), .feedback_mult_valid_o(feedback_mult_valid_o));

/* File: dv/ckd_load.sv */
// Board load on one output pair, counting rising edges of the true line.
// Assumes clk_i stands for the output clock.
`timescale 1ns/1ps
module ckd_load (
	input wire logic clk_i,
	input wire logic clr_i,
	input wire ckd_pkg::ckd_pin_s pin_i,
	output logic [7:0] edges_o
);
	import ckd_pkg::*;
	logic last_q;
	wire logic hi_w = pin_i.true_o && !pin_i.oe_n;
	// A released pair counts as low, so a tri-stated bank never counts.
	always_ff @(posedge clk_i) begin
		last_q <= hi_w;
		edges_o <= clr_i ? 8'h00 : edges_o + 8'(hi_w && !last_q);
	end
endmodule : ckd_load

/* File: dv/clock_driver_output_config_tb.sv */
// Bench for the output control block, one task per scenario.
// Assumes pin changes settle within eight clocks.
`timescale 1ns/1ps
module clock_driver_output_config_tb;
	import ckd_pkg::*;
	logic clk = 0, rst = 1, we = 0, cyc = 0, stb = 0, ack, mval, pd_n = 1, sty = 0, clr = 0;
	logic [31:0] adr = 32'h0, wd = 32'h0, rd, r;
	logic [4:0] en_n = 5'h1f;
	logic [3:0] mult;
	logic [1:0] ifs [6];
	ckd_pin_s [5:0] pins;
	logic [7:0] e0, e5, z;
	int num_errors = 0, n_checks = 0;
	// Four nanosecond clock.
	always #2 clk = ~clk;
	ckd_output_ctrl ckd_output_ctrl_inst (.clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(wd),
		.wb_dat_o(rd), .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_ack_o(ack), .power_down_n_i(pd_n), .disable_style_select_i(sty),
		.bank_output_enable_n_i(en_n), .bank_clock_out_o(pins), .bank_if_sel_o(ifs),
		.feedback_mult_o(mult), .feedback_mult_valid_o(mval));
	ckd_load ckd_load_inst (.clk_i(clk), .clr_i(clr), .pin_i(pins[0]), .edges_o(e0));
	ckd_load ckd_load_fb_inst (.clk_i(clk), .clr_i(clr), .pin_i(pins[5]), .edges_o(e5));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	// One classic cycle; the request stands until ack is seen at an edge.
	task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d);
		int t;
		t = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk);
			t++;
		end while (ack !== 1'b1 && t < 20);
		r = rd;
		chk(ack, 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb
	// Loads the low word, lets enables reach a boundary, then counts 64 clocks.
	task automatic meas(input logic [31:0] lo);
		wb(32'h0, 1'b1, lo);
		repeat (8) @(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (64) @(posedge clk);
	endtask : meas
	function automatic logic near(input logic [7:0] a, input logic [7:0] b);
		return a + 8'h1 >= b && b + 8'h1 >= a;
	endfunction : near
	task automatic t_regs();
		wb(32'h4, 1'b1, 32'hf0bc_def0);
		wb(32'h4, 1'b0, 32'h0);
		chk(r, 32'h00bc_def0);
		wb(32'hc, 1'b1, 32'h1234_5678);
		wb(32'hc, 1'b0, 32'h0);
		chk(r, 32'h0);
	endtask : t_regs
	task automatic t_fbn();
		logic [3:0] tab [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'ha, 4'hc};
		for (int c = 0; c < 16; c++) begin
			wb(32'h4, 1'b1, 32'(c) << 16);
			repeat (2) @(posedge clk);
			chk(mval, c < 9);
			if (c < 9) chk(mult, tab[c]);
		end
	endtask : t_fbn
	task automatic t_ifs();
		logic [31:0] v;
		v = 32'h0;
		for (int b = 0; b < 6; b++) v |= 32'(b % 4) << (14 - 2 * b);
		wb(32'h4, 1'b1, v);
		repeat (2) @(posedge clk);
		for (int b = 0; b < 6; b++) chk(ifs[b], 32'(b % 4));
	endtask : t_ifs
	task automatic t_div();
		en_n <= 5'h00;
		meas(32'h0);
		z = e0;
		chk(pins[0].true_o, 1'b1);
		meas({2'h0, SKEW_INV, 25'h0});
		chk(near(e0, z), 1'b1);
		chk(pins[0].true_o, 1'b0);
		meas({2'h0, SKEW_DIV2, 25'h0});
		chk(near(e0, 8'h20), 1'b1);
		meas({2'h0, SKEW_DIV4, 25'h0});
		chk(near(e0, 8'h10), 1'b1);
		meas({2'h0, 5'h13, 25'h0});
		chk(near(e0, z), 1'b1);
		chk(pins[0].true_o, 1'b1);
	endtask : t_div
	// Feedback set to divide by two stays still while all pins disable the banks, and runs once bank 0 is enabled.
	task automatic t_mrst();
		en_n <= 5'h1f;
		meas(32'h11);
		chk(e5, 8'h0);
		wb(32'h8, 1'b0, 32'h0);
		chk(r[9:4], 6'h20);
		en_n <= 5'h1e;
		meas(32'h11);
		chk(near(e5, 8'h20), 1'b1);
		wb(32'h8, 1'b0, 32'h0);
		chk(r[9:4], 6'h01);
	endtask : t_mrst
	task automatic t_pd();
		pd_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk(pins & {6{3'h1}}, {6{3'h1}});
		// The stop level is only changed while the style pin is low, so park_w never holds while parked pins move.
		wb(32'h4, 1'b1, 32'h0400_0000);
		sty <= 1'b1;
		repeat (8) @(posedge clk);
		chk(pins, {6{3'h2}});
		sty <= 1'b0;
		wb(32'h4, 1'b1, 32'h0);
		sty <= 1'b1;
		repeat (8) @(posedge clk);
		chk(pins, {6{3'h4}});
	endtask : t_pd
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_fbn();
		t_ifs();
		t_div();
		t_mrst();
		t_pd();
		summarize();
	end
	// Watchdog, far beyond the roughly 700 clocks the scenarios need.
	initial begin
		#80000;
		num_errors++;
		summarize();
	end
endmodule : clock_driver_output_config_tb
